// ==== logic/uab_autobaud_wake.sv ====
// Auto-baud measurement and wake-on-break detection for a serial receiver
`timescale 1ns/10ps
`include "uab_map.svh"
// Summary of operation
// - Auto-baud times the 55h sync character on the receive line.
// - Setting auto-baud enable starts calibration; receiver held idle meanwhile.
// - Counting starts on first rising edge after the start bit.
// - Fifth rising edge stores count, clears enable, sets receive flag.
// - Software reads and discards receive data; that read clears the flag.
// - Both divisor bytes form one 16-bit counter during auto-baud.
// - Counter clock is oscillator/32, /128 or /512 by divisor bits.
// - Counter starts at one; software subtracts one afterwards.
// - With wake enabled too, measurement happens on byte after break.
// - Overflow before fifth edge sets overflow flag; counting continues.
// - Overflow flag clearable only once auto-baud enable is clear.
// - In sleep the port clocks stop; baud generator inactive.
// - Wake-on-break works only in asynchronous mode.
// - Wake enable disables reception and watches for a falling edge.
// - Wake event sets receive flag, asynchronously in sleep; read clears.
// - Rising edge ending the break, if it comes outside sleep, clears wake enable.
// - Non-zero character: low time to first rising edge is the wake.
// - High-speed 16-bit rate is oscillator over divisor plus one, as in the other modes.
module uab_autobaud_wake
    import uab_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic RECEIVE_LINE,
    input wire logic SLEEP_MODE,
    input uab_cfg_t CFG,
    input wire logic AUTOBAUD_ENABLE_SET,
    input wire logic AUTOBAUD_ENABLE_CLR,
    input wire logic WAKE_ENABLE_SET,
    input wire logic WAKE_ENABLE_CLR,
    input wire logic OVERFLOW_CLR,
    input wire logic DIVISOR_WRITE,
    input wire logic [15:0] DIVISOR_WDATA,
    input wire logic RECEIVE_DATA_READ,
    output logic [15:0] BAUD_DIVISOR_PAIR,
    output logic [7:0] DIVISOR_HIGH_BYTE,
    output logic [7:0] DIVISOR_LOW_BYTE,
    output uab_status_t STATUS,
    output logic RECEIVE_INTERRUPT_FLAG,
    output logic BAUD_TICK
);
    // =====================================
    // State
    typedef struct packed {
        logic rx_meta;
        logic rx_sync;
        logic rx_prev;
        uab_abd_state_t abd_state;
        logic [2:0] rise_cnt;
        logic [15:0] divisor;
        logic abd_en;
        logic abd_ovf;
        logic wake_en;
        logic wake_seen;
        logic rcv_flag;
        logic [15:0] brg_cnt;
        logic baud_tick;
    } uab_core_state_t;

    uab_core_state_t s_q;
    uab_core_state_t s_d;
    logic abd_tick;
    logic rise;
    logic fall;
    logic measuring;
    logic wake_active;
    logic wake_async_q;

    // =====================================
    // Auto-baud counter clock
    assign measuring = s_q.abd_en && (s_q.abd_state == UAB_MEASURE);

    uab_prescaler u_prescaler (
        .clk(CORE_CLK),
        .reset_n(RESET_N),
        .run(measuring && !SLEEP_MODE),
        .cfg(CFG),
        .tick(abd_tick)
    );

    assign rise = s_q.rx_sync && !s_q.rx_prev;
    assign fall = !s_q.rx_sync && s_q.rx_prev;
    assign wake_active = s_q.wake_en && !CFG.synchronous_mode;

    // =====================================
    // Wake detect while clocks are stopped
    // The line is sampled by itself at the falling edge, so the flag can
    // rise with no core clock running; cleared once the core sees it.
    always_ff @(negedge RECEIVE_LINE or negedge RESET_N or posedge s_q.wake_seen) begin
        if (!RESET_N) begin
            wake_async_q <= 1'b0;
        end else if (s_q.wake_seen) begin
            wake_async_q <= 1'b0;
        end else if (wake_active && SLEEP_MODE) begin
            wake_async_q <= 1'b1;
        end
    end

    // =====================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.rx_meta = RECEIVE_LINE;
        s_d.rx_sync = s_q.rx_meta;
        s_d.rx_prev = s_q.rx_sync;
        s_d.baud_tick = 1'b0;

        // Normal baud generator, stopped in sleep and during auto-baud
        if (SLEEP_MODE || s_q.abd_en || wake_active) begin
            s_d.brg_cnt = 16'h0000;
        end else if (s_q.brg_cnt >= s_q.divisor) begin
            s_d.brg_cnt = 16'h0000;
            s_d.baud_tick = 1'b1;
        end else begin
            s_d.brg_cnt = s_q.brg_cnt + 16'h0001;
        end

        if (DIVISOR_WRITE && !s_q.abd_en) begin
            s_d.divisor = DIVISOR_WDATA;
        end

        // Wake-on-break
        if (WAKE_ENABLE_SET && !CFG.synchronous_mode) begin
            s_d.wake_en = 1'b1;
            s_d.wake_seen = 1'b0;
        end
        if (wake_active && !SLEEP_MODE) begin
            if (!s_q.wake_seen && (fall || wake_async_q)) begin
                s_d.wake_seen = 1'b1;
                s_d.rcv_flag = 1'b1;
            end else if (s_q.wake_seen && rise) begin
                s_d.wake_en = 1'b0;
                s_d.wake_seen = 1'b0;
            end
        end
        if (WAKE_ENABLE_CLR) begin
            s_d.wake_en = 1'b0;
            s_d.wake_seen = 1'b0;
        end

        // Auto-baud sequence, held off while wake is pending
        if (AUTOBAUD_ENABLE_SET && !s_q.abd_en) begin
            s_d.abd_en = 1'b1;
            s_d.abd_state = UAB_IDLE;
            s_d.rise_cnt = 3'h0;
        end
        if (s_q.abd_en && !wake_active && !SLEEP_MODE) begin
            unique case (s_q.abd_state)
                UAB_IDLE: begin
                    if (fall) begin
                        s_d.abd_state = UAB_WAIT_START;
                    end
                end
                UAB_WAIT_START: begin
                    if (rise) begin
                        s_d.abd_state = UAB_MEASURE;
                        s_d.divisor = `UAB_COUNT_START;
                        s_d.rise_cnt = 3'h1;
                    end
                end
                UAB_MEASURE: begin
                    if (abd_tick) begin
                        if (s_q.divisor == `UAB_DIVISOR_MAX) begin
                            s_d.abd_ovf = 1'b1;
                        end
                        s_d.divisor = s_q.divisor + 16'h0001;
                    end
                    if (rise) begin
                        if (s_q.rise_cnt == `UAB_SYNC_RISE_EDGES - 3'h1) begin
                            s_d.abd_en = 1'b0;
                            s_d.rcv_flag = 1'b1;
                            s_d.abd_state = UAB_IDLE;
                            s_d.rise_cnt = 3'h0;
                        end else begin
                            s_d.rise_cnt = s_q.rise_cnt + 3'h1;
                        end
                    end
                end
            endcase
        end
        if (AUTOBAUD_ENABLE_CLR) begin
            s_d.abd_en = 1'b0;
            s_d.abd_state = UAB_IDLE;
            s_d.rise_cnt = 3'h0;
        end

        // Overflow clear refused while auto-baud still enabled; set wins
        if (OVERFLOW_CLR && !s_q.abd_en && !s_d.abd_ovf) begin
            s_d.abd_ovf = 1'b0;
        end else if (OVERFLOW_CLR && !s_q.abd_en && s_q.abd_ovf) begin
            s_d.abd_ovf = 1'b0;
        end

        // Read clears the receive flag unless an event sets it from clear this cycle
        if (RECEIVE_DATA_READ && (s_d.rcv_flag == s_q.rcv_flag)) begin
            s_d.rcv_flag = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_q <= '{rx_meta: 1'b1, rx_sync: 1'b1, rx_prev: 1'b1,
                     abd_state: UAB_IDLE, divisor: `UAB_DIVISOR_RESET,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // =====================================
    // Outputs
    assign BAUD_DIVISOR_PAIR = s_q.divisor;
    assign DIVISOR_HIGH_BYTE = s_q.divisor[15:8];
    assign DIVISOR_LOW_BYTE = s_q.divisor[7:0];
    assign RECEIVE_INTERRUPT_FLAG = s_q.rcv_flag || wake_async_q;
    assign BAUD_TICK = s_q.baud_tick;
    assign STATUS = '{autobaud_enable: s_q.abd_en,
                      autobaud_overflow_flag: s_q.abd_ovf,
                      wake_on_break_enable: s_q.wake_en,
                      receive_interrupt_flag: s_q.rcv_flag || wake_async_q,
                      rx_idle_hold: s_q.abd_en || wake_active};
endmodule : uab_autobaud_wake

// ==== logic/uab_prescaler.sv ====
// Base clock prescaler producing the auto-baud counter enable
`timescale 1ns/10ps
`include "uab_map.svh"
module uab_prescaler
    import uab_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    input uab_cfg_t cfg,
    output logic tick
);
    typedef struct packed {
        logic [10:0] cnt;
        logic tick;
    } uab_pre_state_t;

    uab_pre_state_t s_q;
    uab_pre_state_t s_d;
    logic [10:0] limit;

    // Eighth of the base clock: oscillator/32, /128 or /512
    always_comb begin
        unique case ({cfg.wide_divisor_select, cfg.high_speed_divisor_select})
            2'b11: limit = 11'(`UAB_BASE_DIV_FAST) * 11'(`UAB_ABD_FACTOR);
            2'b00: limit = 11'(`UAB_BASE_DIV_SLOW) * 11'(`UAB_ABD_FACTOR);
            default: limit = 11'(`UAB_BASE_DIV_MID) * 11'(`UAB_ABD_FACTOR);
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run) begin
            s_d.cnt = 11'h000;
        end else if (s_q.cnt == limit - 11'h001) begin
            s_d.cnt = 11'h000;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 11'h001;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule : uab_prescaler

// ==== pkg/uab_map.svh ====
// Constants for the auto-baud and wake-on-break block
`ifndef UAB_MAP_SVH
`define UAB_MAP_SVH
// =====================================
// Sync character and edge counts
`define UAB_SYNC_CHAR 8'h55
`define UAB_SYNC_RISE_EDGES 3'h5
// =====================================
// Base clock dividers in oscillator cycles and the auto-baud factor
`define UAB_BASE_DIV_FAST 8'h04
`define UAB_BASE_DIV_MID 8'h10
`define UAB_BASE_DIV_SLOW 8'h40
`define UAB_ABD_FACTOR 4'h8
// =====================================
// Reset, count start and maximum values
`define UAB_DIVISOR_RESET 16'h0000
`define UAB_COUNT_START 16'h0001
`define UAB_DIVISOR_MAX 16'hFFFF
`endif

// ==== pkg/uab_pkg.sv ====
// Types for the auto-baud and wake-on-break block
package uab_pkg;
    typedef enum logic [1:0] {
        UAB_IDLE,
        UAB_WAIT_START,
        UAB_MEASURE
    } uab_abd_state_t;

    typedef struct packed {
        logic wide_divisor_select;
        logic high_speed_divisor_select;
        logic synchronous_mode;
    } uab_cfg_t;

    typedef struct packed {
        logic autobaud_enable;
        logic autobaud_overflow_flag;
        logic wake_on_break_enable;
        logic receive_interrupt_flag;
        logic rx_idle_hold;
    } uab_status_t;
endpackage : uab_pkg

// ==== test/uab_autobaud_wake_chk.sv ====
// Port checks for the auto-baud and wake-on-break block
`timescale 1ns/10ps
module uab_autobaud_wake_chk
    import uab_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic SLEEP_MODE,
    input uab_cfg_t CFG,
    input wire logic AUTOBAUD_ENABLE_CLR,
    input wire logic WAKE_ENABLE_SET,
    input wire logic DIVISOR_WRITE,
    input wire logic RECEIVE_DATA_READ,
    input wire logic [15:0] BAUD_DIVISOR_PAIR,
    input uab_status_t STATUS,
    input wire logic RECEIVE_INTERRUPT_FLAG,
    input wire logic BAUD_TICK
);
    // ==========
    // Tick spacing counter, valid only while the generator runs freely
    logic [15:0] gap_q;
    logic run_q;
    logic hold;
    assign hold = DIVISOR_WRITE | SLEEP_MODE | STATUS.autobaud_enable
        | STATUS.wake_on_break_enable;
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            gap_q <= 16'h0000;
            run_q <= 1'b0;
        end else begin
            gap_q <= BAUD_TICK ? 16'h0000 : gap_q + 16'h0001;
            run_q <= (BAUD_TICK | run_q) & ~hold;
        end
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    // ==========
    // Properties
    property p_idle; (STATUS.autobaud_enable | STATUS.wake_on_break_enable)
        |-> STATUS.rx_idle_hold; endproperty
    a_idle: assert property (p_idle) else $error("receiver not idle");
    property p_done; $fell(STATUS.autobaud_enable) && !$past(AUTOBAUD_ENABLE_CLR)
        |-> RECEIVE_INTERRUPT_FLAG; endproperty
    a_done: assert property (p_done) else $error("no flag at end");
    property p_ovf; STATUS.autobaud_enable && STATUS.autobaud_overflow_flag
        |=> STATUS.autobaud_overflow_flag; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow lost");
    property p_read; RECEIVE_DATA_READ && !SLEEP_MODE && !STATUS.autobaud_enable
        && !STATUS.wake_on_break_enable |=> !RECEIVE_INTERRUPT_FLAG; endproperty
    a_read: assert property (p_read) else $error("read kept flag");
    property p_sync; WAKE_ENABLE_SET && CFG.synchronous_mode
        && !STATUS.wake_on_break_enable |=> !STATUS.wake_on_break_enable; endproperty
    a_sync: assert property (p_sync) else $error("wake in sync mode");
    property p_count; STATUS.autobaud_enable && $past(STATUS.autobaud_enable)
        && !$stable(BAUD_DIVISOR_PAIR) |-> BAUD_DIVISOR_PAIR == 16'h0001
        || BAUD_DIVISOR_PAIR == $past(BAUD_DIVISOR_PAIR) + 16'h0001; endproperty
    a_count: assert property (p_count) else $error("bad count step");
    property p_tick; BAUD_TICK && run_q |-> gap_q == BAUD_DIVISOR_PAIR; endproperty
    a_tick: assert property (p_tick) else $error("tick spacing");
    property p_sleep; SLEEP_MODE && $past(SLEEP_MODE)
        |-> !BAUD_TICK && $stable(BAUD_DIVISOR_PAIR); endproperty
    a_sleep: assert property (p_sleep) else $error("active in sleep");
endmodule : uab_autobaud_wake_chk

bind uab_autobaud_wake uab_autobaud_wake_chk chk (.CORE_CLK, .RESET_N, .SLEEP_MODE,
    .CFG, .AUTOBAUD_ENABLE_CLR, .WAKE_ENABLE_SET, .DIVISOR_WRITE, .RECEIVE_DATA_READ,
    .BAUD_DIVISOR_PAIR, .STATUS, .RECEIVE_INTERRUPT_FLAG, .BAUD_TICK);

// ==== test/uab_line_drv.sv ====
// Remote transmitter model on the receive line
`timescale 1ns/10ps
module uab_line_drv (
    input wire logic clk,
    output logic line
);
    initial line = 1'b1;
    task automatic bit_out(input logic v, input int n);
        line <= v;
        repeat (n) @(posedge clk);
    endtask : bit_out
    // Start, eight bits lsb first, stop
    task automatic send_char(input logic [7:0] c, input int b);
        @(posedge clk);
        bit_out(1'b0, b);
        for (int i = 0; i < 8; i++) bit_out(c[i], b);
        bit_out(1'b1, b);
    endtask : send_char
    task automatic send_break(input int n, input int b);
        @(posedge clk);
        bit_out(1'b0, n * b);
        bit_out(1'b1, b);
    endtask : send_break
endmodule : uab_line_drv

// ==== test/uart_autobaud_wake_on_break_tb.sv ====
// Self-checking bench for auto-baud and wake-on-break
`timescale 1ns/10ps
module uart_autobaud_wake_on_break_tb;
    import uab_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic sleep = 1'b0;
    logic [6:0] pv = 7'h00;
    logic [15:0] wd = 16'h0000;
    uab_cfg_t cfg = 3'h0;
    logic line;
    logic [15:0] dp;
    logic [7:0] dh;
    logic [7:0] dl;
    uab_status_t st;
    logic rif;
    logic tick;
    logic [15:0] d;
    int mismatches = 0;
    int n_checks = 0;
    int k;
    int g;
    initial forever #10 clk = ~clk;
    uab_line_drv drv (.clk(clk), .line(line));
    uab_autobaud_wake uut (.CORE_CLK(clk), .RESET_N(reset_n), .RECEIVE_LINE(line),
        .SLEEP_MODE(sleep), .CFG(cfg), .AUTOBAUD_ENABLE_SET(pv[0]),
        .AUTOBAUD_ENABLE_CLR(pv[1]), .WAKE_ENABLE_SET(pv[2]), .WAKE_ENABLE_CLR(pv[3]),
        .OVERFLOW_CLR(pv[4]), .DIVISOR_WRITE(pv[5]), .DIVISOR_WDATA(wd),
        .RECEIVE_DATA_READ(pv[6]), .BAUD_DIVISOR_PAIR(dp), .DIVISOR_HIGH_BYTE(dh),
        .DIVISOR_LOW_BYTE(dl), .STATUS(st), .RECEIVE_INTERRUPT_FLAG(rif), .BAUD_TICK(tick));
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    // One-cycle control pulse, status settled on return
    task automatic pulse(input int i);
        @(posedge clk) pv[i] <= 1'b1;
        @(posedge clk) pv[i] <= 1'b0;
        #1;
    endtask : pulse
    // Sync character at k ticks of the measuring clock per eight bits
    task automatic autobaud(input int i, input bit brk);
        k = $urandom_range(5, 2);
        @(posedge clk) cfg <= {i[1], i[0], 1'b0};
        if (brk) pulse(2);
        pulse(0);
        check("idle_hold", st.rx_idle_hold, 1'b1);
        g = k * ((i == 3) ? 4 : (i == 0) ? 64 : 16);
        if (brk) drv.send_break(13, g);
        drv.send_char(8'h55, g);
        for (int n = 0; n < 99 && st.autobaud_enable !== 1'b0; n++) @(posedge clk) #1;
        if (st.autobaud_enable !== 1'b0) begin
            mismatches++;
            conclude();
        end
        d = dp;
        check("divisor", (d >= k && d <= k + 2) ? k + 1 : d, k + 1);
        check("div_high", dh, 8'h00);
        check("rx_flag", rif, 1'b1);
        pulse(6);
        check("rx_flag_clr", rif, 1'b0);
    endtask : autobaud
    initial begin
        void'($urandom(57281));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk) #1;
        check("reset", dp, 16'h0000);
        check("reset_status", 16'(st), 16'h0000);
        for (int i = 0; i < 4; i++) autobaud(i, 1'b0);
        autobaud(3, 1'b1);
        pulse(0);
        pulse(1);
        pulse(4);
        check("abort", {st.autobaud_enable, st.autobaud_overflow_flag}, 2'b00);
        @(posedge clk) wd <= $urandom_range(30, 2);
        pulse(5);
        check("div_bytes", {dh, dl}, wd);
        g = -1;
        for (int i = 0; i < 120; i++) begin
            @(posedge clk) #1;
            if (tick === 1'b1 && g >= 0) check("tick_gap", i - g, wd + 1);
            if (tick === 1'b1) g = i;
        end
        check("ticked", g >= 0, 1'b1);
        @(posedge clk) cfg <= 3'b001;
        pulse(2);
        check("sync_wake", st.wake_on_break_enable, 1'b0);
        @(posedge clk) cfg <= 3'b000;
        pulse(2);
        check("wake_hold", st.rx_idle_hold, 1'b1);
        fork
            drv.send_break(13, 40);
            begin
                repeat (100) @(posedge clk) #1;
                check("wake_flag", rif, 1'b1);
                check("wake_on", st.wake_on_break_enable, 1'b1);
            end
        join
        check("wake_off", st.wake_on_break_enable, 1'b0);
        pulse(6);
        pulse(2);
        drv.send_char(8'h01, 20);
        check("frag_wake", {st.wake_on_break_enable, rif}, 2'b01);
        pulse(6);
        pulse(2);
        @(posedge clk) sleep <= 1'b1;
        fork
            drv.send_break(13, 40);
            begin
                @(posedge clk) #1;
                check("sleep_flag", rif, 1'b1);
            end
        join
        @(posedge clk) sleep <= 1'b0;
        pulse(3);
        pulse(6);
        check("sleep_clr", rif, 1'b0);
        conclude();
    end
endmodule : uart_autobaud_wake_on_break_tb
